// File: rtl/iss_pkg.sv
// Shared constants and types of the sensor control port and frame sequencer
package iss_pkg;

	// --------------------------------------------------------------
	// Serial access layout
	// --------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam logic [4:0] BIT_FIRST = 5'h00;
	localparam logic [4:0] BIT_ADDR_LAST = 5'h07;
	localparam logic [4:0] BIT_DATA_FIRST = 5'h08;
	localparam logic [4:0] BIT_LAST = 5'h17;

	// --------------------------------------------------------------
	// Register map and reset values
	// --------------------------------------------------------------
	localparam logic [6:0] ADDR_EXP_MODE = 7'h46;
	localparam logic [6:0] ADDR_EXP_LOW = 7'h47;
	localparam logic [6:0] ADDR_EXP_HIGH = 7'h48;
	localparam logic [6:0] ADDR_FRAME_COUNT = 7'h50;
	localparam logic [6:0] ADDR_STATUS = 7'h7F;
	localparam logic [15:0] EXP_MODE_RST = 16'h0000;
	localparam logic [15:0] EXP_LOW_RST = 16'h0010;
	localparam logic [15:0] EXP_HIGH_RST = 16'h0000;
	localparam logic [15:0] FRAME_COUNT_RST = 16'h0001;
	localparam int EXT_MODE_BIT = 0;
	localparam int STAT_INTEG_BIT = 0;
	localparam int STAT_FOT_BIT = 1;
	localparam int STAT_READ_BIT = 2;
	localparam int STAT_HOLD_BIT = 3;
	localparam int STAT_PEND_LSB = 4;

	// --------------------------------------------------------------
	// Sequencer and timing
	// --------------------------------------------------------------
	localparam logic [1:0] PEND_MAX = 2'h2;
	localparam logic [15:0] FOT_TICKS_DEF = 16'h0014;
	localparam logic [15:0] READ_TICKS_DEF = 16'h00C8;
	localparam int CLK_PERIOD_NS = 8;
	localparam int SPI_MAX_MHZ = 30;
	localparam int SPI_LAUNCH_NS = 8;
	localparam int SPI_LAUNCH_CYC = (SPI_LAUNCH_NS / CLK_PERIOD_NS < 1) ? 1 :
		SPI_LAUNCH_NS / CLK_PERIOD_NS;

	// --------------------------------------------------------------
	// Synchroniser lanes
	// --------------------------------------------------------------
	localparam int SYNC_W = 6;
	localparam int SY_LINK = 0;
	localparam int SY_REQ = 1;
	localparam int SY_EXP = 2;
	localparam int SY_SCK = 3;
	localparam int SY_EN = 4;
	localparam int SY_SDI = 5;

	typedef enum logic [2:0] {
		E_IDLE = 3'b001,
		E_INT = 3'b010,
		E_HOLD = 3'b100
	} iss_exp_state_t;

	typedef enum logic [2:0] {
		R_IDLE = 3'b001,
		R_FOT = 3'b010,
		R_READ = 3'b100
	} iss_ro_state_t;

endpackage

// File: rtl/iss_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module iss_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Asynchronous in, synchronised out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// File: rtl/iss_spi.sv
// Serial register port: 24-bit access decoder and read data launcher
`timescale 1ns/1ps
module iss_spi
	import iss_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Synchronised serial pins
	input wire logic sck,
	input wire logic en,
	input wire logic sdi,
	// Register side
	input wire logic [DATA_W-1:0] rd_data,
	output logic [ADDR_W-1:0] addr_q,
	output logic [DATA_W-1:0] wr_data_q,
	output logic wr_pulse_q,
	// Serial output
	output logic spi_out_q
);
	logic sck_prev_q;
	logic [4:0] cnt_q;
	logic dir_q;
	logic full_q;
	logic rd_act_q;
	logic [DATA_W-1:0] sh_q;
	logic [DATA_W-1:0] rd_sh_q;

	wire sck_rise = sck & ~sck_prev_q;
	wire sck_fall = ~sck & sck_prev_q;
	wire at_last = cnt_q == BIT_LAST;
	wire rd_load = sck_fall & ~dir_q & (cnt_q == BIT_DATA_FIRST);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sck_prev_q <= 1'b0;
			cnt_q <= BIT_FIRST;
			dir_q <= 1'b0;
			full_q <= 1'b0;
			rd_act_q <= 1'b0;
			sh_q <= '0;
			rd_sh_q <= '0;
			addr_q <= '0;
			wr_data_q <= '0;
			wr_pulse_q <= 1'b0;
			spi_out_q <= 1'b0;
		end else begin
			sck_prev_q <= sck;
			wr_pulse_q <= 1'b0;
			if (!en) begin
				// Dropping the enable aborts the access; nothing is committed
				cnt_q <= BIT_FIRST;
				full_q <= 1'b0;
				rd_act_q <= 1'b0;
				spi_out_q <= 1'b0;
			end else begin
				if (sck_rise) begin
					sh_q <= {sh_q[DATA_W-2:0], sdi}; // see R1
					cnt_q <= at_last ? BIT_FIRST : cnt_q + 5'h01; // see R5, R9
					if (cnt_q == BIT_FIRST)
						dir_q <= sdi; // see R6
					if (cnt_q == BIT_ADDR_LAST)
						addr_q <= {sh_q[ADDR_W-2:0], sdi}; // see R7
					if (at_last) begin
						wr_data_q <= {sh_q[DATA_W-2:0], sdi}; // see R8
						full_q <= 1'b1;
					end
				end
				if (sck_fall) begin
					if (full_q) begin
						wr_pulse_q <= dir_q; // see R1, R8
						full_q <= 1'b0;
					end
					if (rd_load) begin
						spi_out_q <= rd_data[DATA_W-1]; // see R10
						rd_sh_q <= {rd_data[DATA_W-2:0], 1'b0};
						rd_act_q <= 1'b1;
					end else if (rd_act_q && cnt_q != BIT_FIRST) begin
						spi_out_q <= rd_sh_q[DATA_W-1]; // see R10
						rd_sh_q <= {rd_sh_q[DATA_W-2:0], 1'b0};
					end else begin
						spi_out_q <= 1'b0;
						rd_act_q <= 1'b0;
					end
				end
			end
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_bit_range: assert property (cnt_q <= BIT_LAST) else $error("bit count past 24"); // see R5
	a_commit_fall: assert property (wr_pulse_q |-> $past(sck_fall) && $past(full_q)) // see R1
		else $error("write committed off a falling edge");
	a_write_dir: assert property (wr_pulse_q |-> dir_q) else $error("read committed as write"); // see R6
	a_out_launch: assert property ($changed(spi_out_q) && en |-> $past(sck_fall, SPI_LAUNCH_CYC)) // see R10
		else $error("serial output moved off a falling edge");

	c_write: cover property (wr_pulse_q);
	c_read_msb: cover property (rd_load ##1 spi_out_q);
endmodule

// File: rtl/iss_top.sv
// Sensor control: serial register port, register file and frame sequencer
// Operation
// R1: Sample on rising edge, commit on last falling
// R2: Host keeps serial clock at most 30 MHz
// R3: Host raises enable half period before first bit
// R4: Host holds enable one period after last bit
// R5: Access is 24 bits: direction, address, data
// R6: First bit one writes, zero reads
// R7: Seven address bits follow, MSB first
// R8: Write: sixteen data bits MSB first stored
// R9: Back-to-back writes while enable stays high
// R10: Read: value driven MSB first on falling edges
// R11: Host samples read data on rising edges
// R12: Each request captures frame_count frames, reset one
// R13: Internal mode: exposure from registers, starts on request
// R14: Exposure end runs overhead phase then readout
// R15: Next exposure overlaps previous readout
// R16: Short exposure: next overhead starts at readout end
// R17: Early request delayed, overhead right after readout
// R18: Requests during integration queued, two at most
// R19: Request held high: continuous back-to-back frames
// R20: Mode bit zero selects external exposure control (code: mode bit one selects it)
// R21: External: exposure pulse high starts exposure
// R22: External: request ends exposure, extended during readout
// R23: Host holds pulses 8, 10 or 12 link periods
// R24: Reset restores sequencer and registers to defaults
// R25: Request and exposure inputs synchronised, level-sampled
`timescale 1ns/1ps
module iss_top
	import iss_pkg::*;
#(
	parameter logic [15:0] FOT_TICKS = FOT_TICKS_DEF,
	parameter logic [15:0] READ_TICKS = READ_TICKS_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Link clock and frame control pins
	input wire logic link_clk,
	input wire logic frame_req,
	input wire logic exposure_pulse_a,
	// Serial register port
	input wire logic spi_clk,
	input wire logic spi_en,
	input wire logic spi_in,
	output logic spi_out,
	// Sequencer phase indicators
	output logic integ_active_q,
	output logic overhead_active_q,
	output logic readout_active_q
);
	// --------------------------------------------------------------
	// Input synchronisation
	// --------------------------------------------------------------
	logic [SYNC_W-1:0] pins_s;

	iss_sync #(.W(SYNC_W)) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d({spi_in, spi_en, spi_clk, exposure_pulse_a, frame_req, link_clk}), // see R25
		.q(pins_s)
	);

	// --------------------------------------------------------------
	// Serial port and register file
	// --------------------------------------------------------------
	logic [ADDR_W-1:0] spi_addr;
	logic [DATA_W-1:0] spi_wdata;
	logic spi_wr;
	logic [DATA_W-1:0] rd_data;
	logic [15:0] exp_mode_q;
	logic [15:0] exp_low_q;
	logic [15:0] exp_high_q;
	logic [15:0] frame_count_q;
	logic [15:0] status_w;

	iss_spi u_spi (
		.clk(clk),
		.sys_rst(sys_rst),
		.sck(pins_s[SY_SCK]),
		.en(pins_s[SY_EN]),
		.sdi(pins_s[SY_SDI]),
		.rd_data(rd_data),
		.addr_q(spi_addr),
		.wr_data_q(spi_wdata),
		.wr_pulse_q(spi_wr),
		.spi_out_q(spi_out)
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			exp_mode_q <= EXP_MODE_RST; // see R24
			exp_low_q <= EXP_LOW_RST;
			exp_high_q <= EXP_HIGH_RST;
			frame_count_q <= FRAME_COUNT_RST; // see R12
		end else if (spi_wr) begin
			if (spi_addr == ADDR_EXP_MODE)
				exp_mode_q <= spi_wdata; // see R8
			if (spi_addr == ADDR_EXP_LOW)
				exp_low_q <= spi_wdata;
			if (spi_addr == ADDR_EXP_HIGH)
				exp_high_q <= spi_wdata;
			if (spi_addr == ADDR_FRAME_COUNT)
				frame_count_q <= spi_wdata;
		end
	end

	// Unmapped addresses read as zero and ignore writes
	assign rd_data = (spi_addr == ADDR_EXP_MODE) ? exp_mode_q :
		(spi_addr == ADDR_EXP_LOW) ? exp_low_q :
		(spi_addr == ADDR_EXP_HIGH) ? exp_high_q :
		(spi_addr == ADDR_FRAME_COUNT) ? frame_count_q :
		(spi_addr == ADDR_STATUS) ? status_w : 16'h0000;

	// --------------------------------------------------------------
	// Link clock ticks and level sampling
	// --------------------------------------------------------------
	logic lk_prev_q;
	logic req_prev_q;
	iss_exp_state_t e_state_q;
	iss_exp_state_t e_state_d;
	iss_ro_state_t r_state_q;
	iss_ro_state_t r_state_d;
	logic [31:0] exp_cnt_q;
	logic [15:0] ro_cnt_q;
	logic [15:0] frames_left_q;
	logic [1:0] pend_q;

	wire tick = pins_s[SY_LINK] & ~lk_prev_q;
	wire req_lvl = pins_s[SY_REQ];
	wire exp_lvl = pins_s[SY_EXP];
	wire req_rise = tick & req_lvl & ~req_prev_q;
	wire ext_mode = exp_mode_q[EXT_MODE_BIT]; // see R20

	// --------------------------------------------------------------
	// Sequencing decisions
	// --------------------------------------------------------------
	wire [31:0] exp_len = {exp_high_q, exp_low_q};
	wire [31:0] exp_cnt_inc = exp_cnt_q + 32'h00000001;
	wire [15:0] fot_left = FOT_TICKS - ro_cnt_q;
	wire [15:0] read_left = READ_TICKS - ro_cnt_q;
	// Link ticks from now until the last readout tick; an exposure of this length
	// ends on that very tick, so the next overhead phase follows with no gap
	wire [31:0] ro_rem = (r_state_q == R_FOT) ?
		{16'h0000, fot_left} + {16'h0000, READ_TICKS} - 32'h00000001 :
		(r_state_q == R_READ) ? {16'h0000, read_left} - 32'h00000001 : 32'h00000000;
	// Delaying the start keeps the pixels from over-integrating behind a busy readout
	wire timing_ok = (r_state_q == R_IDLE) || (ro_rem <= exp_len); // see R17
	wire e_idle = e_state_q == E_IDLE;
	wire burst_go = (frames_left_q == 16'h0000) && (req_lvl || pend_q != 2'h0); // see R19
	wire int_start = tick & ~ext_mode & e_idle & timing_ok &
		((frames_left_q != 16'h0000) | burst_go); // see R13, R15
	wire ext_start = tick & ext_mode & e_idle & exp_lvl; // see R21
	wire exp_end = tick && e_state_q == E_INT &&
		(ext_mode ? req_lvl : (exp_cnt_inc >= exp_len)); // see R13, R22
	wire ro_last = tick && r_state_q == R_READ && ro_cnt_q == READ_TICKS - 16'h0001;
	wire fot_last = tick && r_state_q == R_FOT && ro_cnt_q == FOT_TICKS - 16'h0001;
	wire ro_free = (r_state_q == R_IDLE) || ro_last;
	wire handoff = ((exp_end && e_state_q == E_INT) || (tick && e_state_q == E_HOLD)) &&
		ro_free; // see R16, R17
	wire pend_use = int_start & burst_go & (pend_q != 2'h0);
	wire pend_add = req_rise & ~ext_mode & ~(int_start & burst_go & (pend_q == 2'h0));
	wire [15:0] burst_left = (frame_count_q == 16'h0000) ? 16'h0000 :
		frame_count_q - 16'h0001;

	always_comb begin
		e_state_d = e_state_q;
		unique case (e_state_q)
			E_IDLE: begin
				if (int_start || ext_start)
					e_state_d = E_INT;
			end
			E_INT: begin
				if (exp_end)
					e_state_d = handoff ? E_IDLE : E_HOLD; // see R22
			end
			E_HOLD: begin
				if (handoff)
					e_state_d = E_IDLE;
			end
			default: e_state_d = E_IDLE;
		endcase
	end

	always_comb begin
		r_state_d = r_state_q;
		unique case (r_state_q)
			R_IDLE: begin
				if (handoff)
					r_state_d = R_FOT; // see R14
			end
			R_FOT: begin
				if (fot_last)
					r_state_d = R_READ; // see R14
			end
			R_READ: begin
				if (ro_last)
					r_state_d = handoff ? R_FOT : R_IDLE; // see R16
			end
			default: r_state_d = R_IDLE;
		endcase
	end

	// --------------------------------------------------------------
	// Sequencer state
	// --------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lk_prev_q <= 1'b0;
			req_prev_q <= 1'b0;
			e_state_q <= E_IDLE; // see R24
			r_state_q <= R_IDLE;
		end else begin
			lk_prev_q <= pins_s[SY_LINK];
			if (tick)
				req_prev_q <= req_lvl; // see R25
			e_state_q <= e_state_d;
			r_state_q <= r_state_d;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			exp_cnt_q <= 32'h00000000;
			ro_cnt_q <= 16'h0000;
		end else begin
			if (e_idle)
				exp_cnt_q <= 32'h00000000;
			else if (tick && e_state_q == E_INT)
				exp_cnt_q <= exp_cnt_inc; // see R13
			if (r_state_d != r_state_q)
				ro_cnt_q <= 16'h0000;
			else if (tick && r_state_q != R_IDLE)
				ro_cnt_q <= ro_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || ext_mode) begin
			frames_left_q <= 16'h0000;
		end else if (int_start) begin
			frames_left_q <= burst_go ? burst_left : frames_left_q - 16'h0001; // see R12
		end
	end

	// A request arriving as one is consumed still counts
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pend_q <= 2'h0;
		end else if (pend_add && !pend_use) begin
			if (pend_q != PEND_MAX)
				pend_q <= pend_q + 2'h1; // see R18
		end else if (pend_use && !pend_add) begin
			pend_q <= pend_q - 2'h1;
		end
	end

	// --------------------------------------------------------------
	// Phase outputs and status
	// --------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			integ_active_q <= 1'b0;
			overhead_active_q <= 1'b0;
			readout_active_q <= 1'b0;
		end else begin
			integ_active_q <= e_state_d != E_IDLE;
			overhead_active_q <= r_state_d == R_FOT;
			readout_active_q <= r_state_d == R_READ;
		end
	end

	always_comb begin
		status_w = 16'h0000;
		status_w[STAT_INTEG_BIT] = e_state_q == E_INT;
		status_w[STAT_FOT_BIT] = r_state_q == R_FOT;
		status_w[STAT_READ_BIT] = r_state_q == R_READ;
		status_w[STAT_HOLD_BIT] = e_state_q == E_HOLD;
		status_w[STAT_PEND_LSB +: 2] = pend_q;
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_count_default: assert property ($past(sys_rst) |-> frame_count_q == FRAME_COUNT_RST) // see R12
		else $error("frame count not one after reset");
	a_reg_store: assert property (spi_wr && spi_addr == ADDR_FRAME_COUNT |=> // see R8
		frame_count_q == $past(spi_wdata)) else $error("frame count write lost");
	a_int_length: assert property (e_state_q == E_INT && !ext_mode && e_state_d != E_INT |-> // see R13
		exp_cnt_inc >= exp_len) else $error("internal exposure ended early");
	a_fot_then_read: assert property (fot_last |=> r_state_q == R_READ) // see R14
		else $error("readout did not follow overhead phase");
	a_no_cut_readout: assert property (r_state_q == R_READ && !ro_last |=> // see R17
		r_state_q == R_READ) else $error("readout interrupted");
	a_queue_limit: assert property (pend_q <= PEND_MAX) else $error("too many queued"); // see R18
	a_ext_end: assert property (ext_mode && exp_end |=> e_state_q != E_INT) // see R22
		else $error("request did not end external exposure");
	a_ext_start: assert property (ext_mode && e_idle ##1 e_state_q == E_INT |-> // see R21, R20
		$past(exp_lvl)) else $error("external exposure without pulse");
	a_hold_wait: assert property (e_state_q == E_HOLD && r_state_q == R_READ && !ro_last |=> // see R16
		e_state_q == E_HOLD) else $error("held exposure released during readout");

	c_overlap: cover property (e_state_q == E_INT && r_state_q == R_READ);
	c_extended: cover property (e_state_q == E_HOLD ##[1:400] r_state_q == R_FOT);
	c_two_queued: cover property (pend_q == PEND_MAX);
endmodule

// File: test/iss_host_model.sv
// Host controller model driving the serial port and the frame control pins
`timescale 1ns/1ps
module iss_host_model (
	// Clocks
	input wire logic clk,
	input wire logic link_clk,
	// Serial port
	output logic spi_clk,
	output logic spi_en,
	output logic spi_in,
	input wire logic spi_out,
	// Frame control pins
	output logic frame_req,
	output logic exposure_pulse_a
);
	// Half of a 96 ns serial period, about 10 MHz
	localparam int HALF = 6;

	// Serial lines idle low, as the pull-downs leave them
	initial begin
		spi_clk = 1'b0;
		spi_en = 1'b0;
		spi_in = 1'b0;
		frame_req = 1'b0;
		exposure_pulse_a = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic link_ticks(input int n);
		repeat (n) @(posedge link_clk);
		wait_clk(1);
	endtask

	// One 24-bit access; keep leaves enable high for a following access
	task automatic spi_access(input logic [23:0] word, input bit keep, output logic [15:0] rd);
		rd = 16'h0000;
		spi_en = 1'b1;
		wait_clk(HALF);
		for (int i = 23; i >= 0; i--) begin
			spi_in = word[i];
			wait_clk(HALF);
			spi_clk = 1'b1;
			if (i < 16) begin
				rd = {rd[14:0], spi_out};
			end
			wait_clk(HALF);
			spi_clk = 1'b0;
		end
		spi_in = 1'b0;
		wait_clk(2 * HALF);
		if (!keep) begin
			spi_en = 1'b0;
			wait_clk(2 * HALF);
		end
	endtask

	// Pulses last whole link periods so the sequencer can see them
	task automatic pulse(input bit exp_pin, input int ticks);
		exposure_pulse_a = exp_pin;
		frame_req = !exp_pin;
		link_ticks(ticks);
		frame_req = 1'b0;
		exposure_pulse_a = 1'b0;
		link_ticks(2);
	endtask
endmodule

// File: test/tb_top.sv
// Self-checking testbench of the sensor control block
`timescale 1ns/1ps
module tb_top;
	import iss_pkg::*;

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic link_clk = 1'b0;
	logic frame_req, exposure_pulse_a, spi_clk, spi_en, spi_in, spi_out;
	logic integ_active_q, overhead_active_q, readout_active_q;
	logic ro_p = 1'b0;
	logic ro_pp = 1'b0;
	logic ov_p = 1'b0;
	logic in_p = 1'b0;
	logic lk_p = 1'b0;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	int n_ro, n_back, ovl, len, first_len, n_fall;
	int seed = 32'h82b8;
	logic [15:0] rnd [3];
	logic [6:0] ra [3] = '{ADDR_EXP_LOW, ADDR_EXP_HIGH, ADDR_FRAME_COUNT};

	always #4 clk = ~clk;
	initial begin
		#13;
		forever #80 link_clk = ~link_clk;
	end

	iss_top #(.FOT_TICKS(16'h0004), .READ_TICKS(16'h0028)) i_dut (
		.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .frame_req(frame_req),
		.exposure_pulse_a(exposure_pulse_a), .spi_clk(spi_clk), .spi_en(spi_en),
		.spi_in(spi_in), .spi_out(spi_out), .integ_active_q(integ_active_q),
		.overhead_active_q(overhead_active_q), .readout_active_q(readout_active_q));

	iss_host_model i_host (
		.clk(clk), .link_clk(link_clk), .spi_clk(spi_clk), .spi_en(spi_en),
		.spi_in(spi_in), .spi_out(spi_out), .frame_req(frame_req),
		.exposure_pulse_a(exposure_pulse_a));

	// --------------------------------------------------------------
	// Phase monitor
	// --------------------------------------------------------------
	always @(posedge clk) begin
		ro_p <= readout_active_q;
		ro_pp <= ro_p;
		ov_p <= overhead_active_q;
		in_p <= integ_active_q;
		lk_p <= link_clk;
		if (readout_active_q && !ro_p) n_ro++;
		if (overhead_active_q && !ov_p && (ro_p || ro_pp)) n_back++;
		if (integ_active_q && readout_active_q) ovl = 1;
		if (integ_active_q && !in_p) len = 0;
		else if (integ_active_q && link_clk && !lk_p) len++;
		if (!integ_active_q && in_p) begin
			if (n_fall == 0) first_len = len;
			n_fall++;
		end
		cyc++;
		if (cyc == 80000) begin
			n_errors++;
			print_verdict();
		end
	end

	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] d, input bit keep);
		logic [15:0] r;
		i_host.spi_access({1'b1, a, d}, keep, r);
	endtask

	task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
		logic [15:0] r;
		i_host.spi_access({1'b0, a, 16'h0000}, 1'b0, r);
		check(r, e);
	endtask

	task automatic clr();
		n_ro = 0;
		n_back = 0;
		ovl = 0;
		n_fall = 0;
		first_len = 0;
	endtask

	// Returns once all phases have been quiet for 100 cycles, or gives up
	task automatic wait_idle();
		int idle;
		idle = 0;
		for (int i = 0; i < 30000 && idle < 100; i++) begin
			@(posedge clk);
			if (integ_active_q || overhead_active_q || readout_active_q) idle = 0;
			else idle++;
		end
		if (idle < 100) n_errors++;
	endtask

	task automatic wait_rise_ro();
		for (int i = 0; i < 3000 && !readout_active_q; i++) @(posedge clk);
		if (!readout_active_q) n_errors++;
		i_host.wait_clk(1);
	endtask

	task automatic set_seq(input logic [15:0] mode, input logic [15:0] exp, input logic [15:0] fc);
		wr(ADDR_EXP_MODE, mode, 1'b1);
		wr(ADDR_EXP_LOW, exp, 1'b1);
		wr(ADDR_EXP_HIGH, 16'h0000, 1'b1);
		wr(ADDR_FRAME_COUNT, fc, 1'b0);
		clr();
	endtask

	task automatic print_verdict();
		if (n_errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		clr();
		repeat (2) @(posedge clk);
		#1 sys_rst = 1'b0;
		i_host.wait_clk(4);
		rd_chk(ADDR_EXP_MODE, EXP_MODE_RST);
		rd_chk(ADDR_EXP_LOW, EXP_LOW_RST);
		rd_chk(ADDR_FRAME_COUNT, 16'h0001);
		rd_chk(7'h10, 16'h0000);
		// Random values, all three written back to back under one enable
		for (int i = 0; i < 3; i++) rnd[i] = 16'($random(seed));
		for (int i = 0; i < 3; i++) wr(ra[i], rnd[i], i < 2);
		for (int i = 0; i < 3; i++) rd_chk(ra[i], rnd[i]);
		// A reset in mid-run returns the registers to their defaults
		@(posedge clk);
		#1 sys_rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 sys_rst = 1'b0;
		i_host.wait_clk(4);
		rd_chk(ADDR_FRAME_COUNT, 16'h0001);
		rd_chk(ADDR_EXP_HIGH, EXP_HIGH_RST);
		rd_chk(ADDR_STATUS, 16'h0000);
		// Two frames, short exposure
		set_seq(16'h0000, 16'h0005, 16'h0002);
		i_host.pulse(1'b0, 12);
		wait_idle();
		check(16'(n_ro), 16'h0002);
		check(16'(first_len inside {[4:6]}), 16'h0001);
		check(16'(ovl), 16'h0001);
		check(16'(n_back), 16'h0001);
		// Three extra requests during a long exposure, one too many
		set_seq(16'h0000, 16'h003C, 16'h0001);
		i_host.pulse(1'b0, 12);
		for (int i = 0; i < 3; i++) i_host.pulse(1'b0, 12);
		wait_idle();
		check(16'(n_ro), 16'h0003);
		// Request held high
		set_seq(16'h0000, 16'h0005, 16'h0001);
		i_host.pulse(1'b0, 300);
		wait_idle();
		check(16'(n_ro >= 5), 16'h0001);
		// External exposure, second exposure and request during readout
		set_seq(16'h0001, 16'h0005, 16'h0001);
		i_host.pulse(1'b1, 12);
		i_host.link_ticks(30);
		check({14'h0000, integ_active_q, readout_active_q}, 16'h0002);
		i_host.pulse(1'b0, 12);
		wait_rise_ro();
		i_host.pulse(1'b1, 12);
		i_host.pulse(1'b0, 12);
		check({14'h0000, integ_active_q, readout_active_q}, 16'h0003);
		wait_idle();
		check(16'(n_ro), 16'h0002);
		check(16'(n_back), 16'h0001);
		print_verdict();
	end
endmodule
